// [testbench/spom_pad_model.sv]
// Purpose: Pads seen from outside: driven, pulled or floating
// Assumes: No external load beyond the internal pulls
// Notes:   Floating pins toggle so an unpulled input never looks stable
module spom_pad_model (
    input  wire logic                          clk,
    input  wire spom_pkg::spom_pad_type        pad,
    output logic [spom_pkg::NUM_PINS-1:0]      pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import spom_pkg::*;
    logic [NUM_PINS-1:0] drift = 56'h55_5555_5555_5555;
    always @(posedge clk) drift <= ~drift;
    always_comb begin
        pad_in = (pad.oe & pad.out) | (~pad.oe & pad.pull_up)
               | (~pad.oe & ~pad.pull_up & ~pad.pull_down & drift);
    end
endmodule // spom_pad_model

// [testbench/spom_top_chk.sv]
// Purpose: Port-level checks for the shared pin ownership mux
// Assumes: One clock, synchronous active-low reset
// Notes:   Pad checks same-cycle: pad drive is combinational
module spom_top_chk (
    input logic                          clk,
    input logic                          rst_n,
    input logic                          s_axi_awvalid,
    input logic                          s_axi_awready,
    input logic                          s_axi_wvalid,
    input logic                          s_axi_wready,
    input logic [1:0]                    s_axi_bresp,
    input logic                          s_axi_bvalid,
    input logic                          s_axi_bready,
    input logic                          s_axi_arvalid,
    input logic                          s_axi_arready,
    input logic                          s_axi_rvalid,
    input spom_pkg::spom_alt_type        alt_lo,
    input spom_pkg::spom_alt_type        alt_hi,
    input logic [spom_pkg::NUM_PINS-1:0] kbi_rise_sense,
    input spom_pkg::spom_pad_type        pad,
    input logic                          irq_pad_in,
    input logic                          irq_pull_up,
    input logic                          irq_pull_down,
    input logic                          branch_pin_level
);
    import spom_pkg::*;
    logic [NUM_PINS-1:0] hi_own;
    logic [NUM_PINS-1:0] lo_own;
    assign hi_own = HI_MASK & alt_hi.en;
    assign lo_own = LO_MASK & alt_lo.en & ~hi_own;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // Pad ownership, pulls and interrupt pin
    // ==========================================================
    property p_rst_pads;
        $rose(rst_n) && alt_lo.en == '0 && alt_hi.en == '0 |-> pad.oe == '0
            && pad.pull_up == '0 && !irq_pull_up && !irq_pull_down;
    endproperty
    a_rst_pads: assert property (p_rst_pads) else $error("reset pads");
    property p_hi_own;
        ((pad.oe ^ alt_hi.oe) & hi_own) == '0
            && ((pad.out ^ alt_hi.out) & hi_own) == '0;
    endproperty
    a_hi_own: assert property (p_hi_own) else $error("hi owner");
    property p_lo_own;
        ((pad.oe ^ alt_lo.oe) & lo_own) == '0
            && ((pad.out ^ alt_lo.out) & lo_own) == '0;
    endproperty
    a_lo_own: assert property (p_lo_own) else $error("lo owner");
    property p_pull_in;
        (pad.oe & (pad.pull_up | pad.pull_down)) == '0
            && (pad.pull_up & pad.pull_down) == '0;
    endproperty
    a_pull_in: assert property (p_pull_in) else $error("pull on out");
    property p_kbi_pd;
        (pad.pull_down & ~(KBI_MASK & lo_own & kbi_rise_sense)) == '0;
    endproperty
    a_kbi_pd: assert property (p_kbi_pd) else $error("stray pull-down");
    property p_branch;
        $past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n)
            |-> branch_pin_level == $past(irq_pad_in, 3);
    endproperty
    a_branch: assert property (p_branch) else $error("branch level");
    // ==========================================================
    // Register bus
    // ==========================================================
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    property p_wr_lat;
        s_wr_taken |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer");
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write resp drop");
endmodule // spom_top_chk

bind spom_top spom_top_chk u_chk (.*);

// [testbench/spom_top_tb_top.sv]
// Purpose: Bus tests of pin ownership, pulls and interrupt pin
// Assumes: Pad model loops driven values back to pad_in
// Notes:   Peripheral enables driven by the bench
module spom_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import spom_pkg::*;
    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    logic [ADDR_W-1:0]   s_axi_awaddr, s_axi_araddr;
    logic [31:0]         s_axi_wdata, s_axi_rdata;
    logic [3:0]          s_axi_wstrb;
    logic [1:0]          s_axi_bresp, s_axi_rresp;
    logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic                s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic                s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic                s_axi_rready, irq_pad_in, irq_pull_up;
    logic                irq_pull_down, irq_request, branch_pin_level;
    spom_alt_type        alt_lo, alt_hi;
    spom_pad_type        pad;
    logic [NUM_PINS-1:0] kbi_rise_sense, pin_level, pad_in;
    logic [3:0]          ic [4] = '{4'h4, 4'h5, 4'h7, 4'h7};
    logic                ip [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic [3:0]          ie [4] = '{4'h0, 4'hA, 4'h7, 4'h4};
    int                  n_fail = 0;
    int                  checks_done = 0;
    always #20 clk = ~clk;
    spom_top DUT (.*);
    spom_pad_model u_pads (.*);
    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input string nm, input logic [63:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid && !s_axi_awready
                   || s_axi_wvalid && !s_axi_wready);
        while (!s_axi_bvalid) @(posedge clk);
        s_axi_bready <= 1'b0;
        chk("bresp", 64'(er), 64'(s_axi_bresp));
    endtask
    task automatic rd_chk(input logic [7:0] a, input string nm,
                          input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(nm, 64'(e), 64'(s_axi_rdata));
        chk("rresp", 64'(er), 64'(s_axi_rresp));
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    task automatic give_verdict();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        {alt_lo, alt_hi} = '0;
        kbi_rise_sense = '0;
        irq_pad_in = 1'b1;
        do_reset();
        chk("pad_oe", 64'h0, 64'(pad.oe));
        chk("pad_pu", 64'h0, 64'(pad.pull_up));
        rd_chk(8'h34, "dir_d", 32'h0, RESP_OKAY);
        rd_chk(8'h38, "pull_d", 32'h0, RESP_OKAY);
        rd_chk(IRQ_CTRL_ADDR, "irq_ctrl", 32'h8, RESP_OKAY);
        axi_wr(8'h90, 32'hFF, RESP_SLVERR);
        rd_chk(8'h90, "unmapped", 32'h0, RESP_SLVERR);
        alt_hi.oe[31] <= 1'b1;
        alt_hi.en[8] <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            alt_lo.en[31] <= i[0];
            alt_hi.en[31] <= i[1];
            rd_chk(8'h3C, "own_d7", i[1] ? 32'hC000 : (i[0] ? 32'h4000 : 32'h0),
                   RESP_OKAY);
            chk("oe_d7", 64'(i[1]), 64'(pad.oe[31]));
        end
        rd_chk(8'h1C, "own_b0", 32'h0, RESP_OKAY);
        alt_hi.en <= '0;
        alt_lo.oe[31] <= 1'b1;
        alt_lo.out[31] <= 1'b1;
        axi_wr(8'h38, 32'hFF, RESP_OKAY);
        rd_chk(8'h30, "data_in", 32'hFF, RESP_OKAY);
        chk("pu_d7", 64'h0, 64'(pad.pull_up[31]));
        axi_wr(8'h34, 32'h80, RESP_OKAY);
        rd_chk(8'h30, "data_lat", 32'h7F, RESP_OKAY);
        chk("drv_d7", 64'h3, 64'({pad.oe[31], pad.out[31]}));
        chk("lvl_d7", 64'h1, 64'(pin_level[31]));
        alt_lo.oe[31] <= 1'b0;
        alt_lo.en[29] <= 1'b1;
        kbi_rise_sense[31] <= 1'b1;
        kbi_rise_sense[29] <= 1'b1;
        repeat (2) @(posedge clk);
        chk("pulls_kbi", 64'h6, 64'({pad.pull_up[31], pad.pull_down[31],
            pad.pull_up[29], pad.pull_down[29]}));
        alt_hi.en[31] <= 1'b1;
        alt_hi.oe[31] <= 1'b0;
        repeat (2) @(posedge clk);
        chk("pulls_adc", 64'hA, 64'({pad.pull_up[31], pad.pull_down[31],
            pad.pull_up[29], pad.pull_down[29]}));
        axi_wr(8'h3C, 32'h0, RESP_OKAY);
        rd_chk(8'h3C, "own_ro", 32'hC400, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            irq_pad_in <= ip[i];
            axi_wr(IRQ_CTRL_ADDR, 32'(ic[i]), RESP_OKAY);
            repeat (4) @(posedge clk);
            chk("irq", 64'(ie[i]), 64'({irq_pull_up, irq_pull_down,
                irq_request, branch_pin_level}));
        end
        rd_chk(IRQ_CTRL_ADDR, "irq_rd", 32'h7, RESP_OKAY);
        alt_lo <= '0;
        alt_hi <= '0;
        do_reset();
        rd_chk(8'h34, "dir_rst", 32'h0, RESP_OKAY);
        chk("irq_rst", 64'h0, 64'({irq_pull_up, irq_pull_down}));
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
endmodule // spom_top_tb_top

// [verilog/spom_pin_select.sv]
// Purpose: Ownership and pad drive for one shared pin
// Assumes: Function enables come from on-chip peripherals, same clock
// Notes:   Purely combinational so pads follow owners without delay
module spom_pin_select #(
    parameter bit HAS_LO = 1'b0,
    parameter bit HAS_HI = 1'b0,
    parameter bit IS_KBI = 1'b0
) (
    input  wire logic               hi_en,
    input  wire logic               hi_out,
    input  wire logic               hi_oe,
    input  wire logic               lo_en,
    input  wire logic               lo_out,
    input  wire logic               lo_oe,
    input  wire logic               kbi_rise,
    input  wire logic               port_dout,
    input  wire logic               port_dir,
    input  wire logic               pull_en,
    output logic                    pad_out,
    output logic                    pad_oe,
    output logic                    pull_up,
    output logic                    pull_down,
    output spom_pkg::spom_owner_type owner
);
    import spom_pkg::*;

    logic as_input;
    logic want_down;

    // ==========================================================
    // Fixed priority select
    // ==========================================================
    always_comb begin
        if (HAS_HI && hi_en) begin // RULE5 RULE6
            owner   = OWN_HI;
            pad_out = hi_out;
            pad_oe  = hi_oe; // RULE7
        end else if (HAS_LO && lo_en) begin // RULE5 RULE6
            owner   = OWN_LO;
            pad_out = lo_out;
            pad_oe  = lo_oe; // RULE7
        end else begin
            owner   = OWN_PORT;
            pad_out = port_dout;
            pad_oe  = port_dir;
        end
        // Pull only while the pin acts as an input, whoever owns it
        as_input  = ~pad_oe;
        want_down = IS_KBI && (owner == OWN_LO) && kbi_rise; // RULE9
        pull_up   = pull_en & as_input & ~want_down; // RULE8 RULE13
        pull_down = pull_en & as_input & want_down; // RULE9 RULE13
    end

endmodule // spom_pin_select

// [verilog/spom_pkg.sv]
// Purpose: Shared constants and types for the shared pin ownership mux
// Assumes: Seven eight-pin ports, pin index = port * 8 + bit
// Notes:   Ports A..G are indices 0..6
package spom_pkg;

    // ==========================================================
    // Pin map
    // ==========================================================
    localparam int NUM_PORTS = 7;
    localparam int PORT_W    = 8;
    localparam int NUM_PINS  = NUM_PORTS * PORT_W;

    // Pins with a lower alternate function (one above port I/O)
    localparam logic [NUM_PINS-1:0] LO_MASK  = 56'h7F_3FFF_FF2F_FF00;
    // Pins where a converter channel sits above the lower alternate
    localparam logic [NUM_PINS-1:0] HI_MASK  = 56'h00_0000_DC00_0000;
    // Keyboard pins whose pull flips to pull-down on rising sense
    localparam logic [NUM_PINS-1:0] KBI_MASK = 56'h10_0000_8C00_0000;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  PORT_STRIDE   = 8'h10;
    localparam logic [1:0]  REG_DATA      = 2'h0;
    localparam logic [1:0]  REG_DIR       = 2'h1;
    localparam logic [1:0]  REG_PULL      = 2'h2;
    localparam logic [1:0]  REG_OWNER     = 2'h3;
    localparam logic [7:0]  IRQ_CTRL_ADDR = 8'h80;

    // External interrupt control fields
    localparam int IRQ_EN_BIT   = 0;
    localparam int IRQ_RISE_BIT = 1;
    localparam int IRQ_PE_BIT   = 2;
    localparam int IRQ_LVL_BIT  = 3;
    localparam int IRQ_CTRL_W   = 3;

    // Reset values: inputs, no pulls, interrupt pin off
    localparam logic [NUM_PINS-1:0]   PIN_RESET  = 56'h00_0000_0000_0000;
    localparam logic [IRQ_CTRL_W-1:0] IRQ_RESET  = 3'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [1:0] {
        OWN_PORT = 2'h0,
        OWN_LO   = 2'h1,
        OWN_HI   = 2'h3
    } spom_owner_type;

    typedef struct packed {
        logic [NUM_PINS-1:0] en;
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
    } spom_alt_type;

    typedef struct packed {
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
        logic [NUM_PINS-1:0] pull_up;
        logic [NUM_PINS-1:0] pull_down;
    } spom_pad_type;

endpackage

// [verilog/spom_top.sv]
// Purpose: Shared pin ownership mux with port registers over AXI4-Lite
// Assumes: Pads and peripherals on clk; pad inputs are asynchronous
// Notes:   Pad drive is combinational from registers and enables

// Function
// RULE1: Interrupt pin feeds request and branch tests
// RULE2: Disabled interrupt pin: no request, no pull
// RULE3: Rising-edge interrupt pin uses pull-down
// RULE4: Reset leaves pins inputs, pulls off
// RULE5: Highest enabled function owns the pin
// RULE6: Converter above keyboard/timer clock above port
// RULE7: Peripheral drives enable; direction selects data read
// RULE8: Pull enable applies whenever pin is input
// RULE9: Rising-sense keyboard pins get pull-down
// RULE10: Software clears flags before enabling interrupts
// RULE11: Software disables sharers before enabling another
// RULE12: Software pulls up or drives unused pins
// RULE13: Pad controls are combinational priority select
module spom_top (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // AXI4-Lite slave
    input  wire logic [spom_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [spom_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // Peripheral side
    input  wire spom_pkg::spom_alt_type    alt_lo,
    input  wire spom_pkg::spom_alt_type    alt_hi,
    input  wire logic [spom_pkg::NUM_PINS-1:0] kbi_rise_sense,
    output logic [spom_pkg::NUM_PINS-1:0]  pin_level,
    // Pad side
    input  wire logic [spom_pkg::NUM_PINS-1:0] pad_in,
    output spom_pkg::spom_pad_type         pad,
    // External interrupt pin
    input  wire logic                      irq_pad_in,
    output logic                           irq_pull_up,
    output logic                           irq_pull_down,
    output logic                           irq_request,
    output logic                           branch_pin_level
);
    import spom_pkg::*;

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic [NUM_PINS-1:0] pad_meta;
    logic [NUM_PINS-1:0] pad_sync;
    logic                irq_meta;
    logic                irq_sync;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pad_meta <= PIN_RESET;
            pad_sync <= PIN_RESET;
            irq_meta <= 1'b0;
            irq_sync <= 1'b0;
        end else begin
            pad_meta <= pad_in;
            pad_sync <= pad_meta;
            irq_meta <= irq_pad_in;
            irq_sync <= irq_meta;
        end
    end

    assign pin_level = pad_sync;

    // ==========================================================
    // Bus handshake state
    // ==========================================================
    logic [ADDR_W-1:0] awaddr_q;
    logic [ADDR_W-1:0] next_awaddr_q;
    logic [31:0]       wdata_q;
    logic [31:0]       next_wdata_q;
    logic              wstrb0_q;
    logic              next_wstrb0_q;
    logic              aw_held;
    logic              next_aw_held;
    logic              w_held;
    logic              next_w_held;
    logic              next_awready;
    logic              next_wready;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_arready;
    logic              next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;
    logic              do_write;

    // ==========================================================
    // Configuration registers
    // ==========================================================
    logic [NUM_PINS-1:0]   port_dout;
    logic [NUM_PINS-1:0]   port_dir;
    logic [NUM_PINS-1:0]   port_pull;
    logic [IRQ_CTRL_W-1:0] irq_ctrl;
    logic [NUM_PINS-1:0]   next_port_dout;
    logic [NUM_PINS-1:0]   next_port_dir;
    logic [NUM_PINS-1:0]   next_port_pull;
    logic [IRQ_CTRL_W-1:0] next_irq_ctrl;
    logic                  next_irq_pull_up;
    logic                  next_irq_pull_down;
    logic                  next_irq_request;

    spom_owner_type owner [NUM_PINS];

    // Address decode helpers
    function automatic logic port_hit(input logic [ADDR_W-1:0] a);
        port_hit = (a[7:4] < 4'(NUM_PORTS)) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
        logic [2:0] p;
        logic [7:0] v;
        logic [15:0] o;
        p = a[6:4];
        v = 8'h00;
        o = 16'h0000;
        read_word = 32'h0000_0000;
        if (a == IRQ_CTRL_ADDR) begin
            read_word[IRQ_CTRL_W-1:0] = irq_ctrl;
            read_word[IRQ_LVL_BIT]    = irq_sync;
        end else if (port_hit(a)) begin
            case (a[3:2])
                REG_DATA: begin
                    // Direction picks latch or pin, even under a peripheral
                    v = (port_dir[p*PORT_W +: PORT_W]
                         & port_dout[p*PORT_W +: PORT_W])
                      | (~port_dir[p*PORT_W +: PORT_W]
                         & pad_sync[p*PORT_W +: PORT_W]); // RULE7
                    read_word[PORT_W-1:0] = v;
                end
                REG_DIR:  read_word[PORT_W-1:0] = port_dir[p*PORT_W +: PORT_W];
                REG_PULL: read_word[PORT_W-1:0] = port_pull[p*PORT_W +: PORT_W];
                REG_OWNER: begin
                    for (int b = 0; b < PORT_W; b++) begin
                        o[2*b +: 2] = owner[p*PORT_W + b];
                    end
                    read_word[15:0] = o;
                end
                default: read_word = 32'h0000_0000;
            endcase
        end
    endfunction

    // ==========================================================
    // Bus next state
    // ==========================================================
    always_comb begin
        next_awaddr_q = awaddr_q;
        next_wdata_q  = wdata_q;
        next_wstrb0_q = wstrb0_q;
        next_aw_held  = aw_held;
        next_w_held   = w_held;
        next_bvalid   = s_axi_bvalid;
        next_bresp    = s_axi_bresp;
        next_rvalid   = s_axi_rvalid;
        next_rdata    = s_axi_rdata;
        next_rresp    = s_axi_rresp;
        do_write      = aw_held && w_held && !s_axi_bvalid;

        if (s_axi_awvalid && s_axi_awready) begin
            next_awaddr_q = s_axi_awaddr;
            next_aw_held  = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wdata_q  = s_axi_wdata;
            next_wstrb0_q = s_axi_wstrb[0];
            next_w_held   = 1'b1;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (port_hit(awaddr_q) || awaddr_q == IRQ_CTRL_ADDR)
                           ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end

        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = read_word(s_axi_araddr);
            next_rresp  = (port_hit(s_axi_araddr)
                           || s_axi_araddr == IRQ_CTRL_ADDR)
                          ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end

        // One write and one read in flight at a time
        next_awready = !next_aw_held && !next_bvalid && !do_write;
        next_wready  = !next_w_held && !next_bvalid && !do_write;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awaddr_q      <= '0;
            wdata_q       <= 32'h0000_0000;
            wstrb0_q      <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            awaddr_q      <= next_awaddr_q;
            wdata_q       <= next_wdata_q;
            wstrb0_q      <= next_wstrb0_q;
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // ==========================================================
    // Register next state
    // ==========================================================
    always_comb begin
        logic [2:0] p;
        p              = awaddr_q[6:4];
        next_port_dout = port_dout;
        next_port_dir  = port_dir;
        next_port_pull = port_pull;
        next_irq_ctrl  = irq_ctrl;
        // Only byte lane 0 carries data; other lanes are ignored
        if (do_write && wstrb0_q) begin
            if (awaddr_q == IRQ_CTRL_ADDR) begin
                next_irq_ctrl = wdata_q[IRQ_CTRL_W-1:0];
            end else if (port_hit(awaddr_q)) begin
                case (awaddr_q[3:2])
                    REG_DATA: next_port_dout[p*PORT_W +: PORT_W] =
                                  wdata_q[PORT_W-1:0];
                    REG_DIR:  next_port_dir[p*PORT_W +: PORT_W] =
                                  wdata_q[PORT_W-1:0];
                    REG_PULL: next_port_pull[p*PORT_W +: PORT_W] =
                                  wdata_q[PORT_W-1:0];
                    default:  next_port_dout = port_dout;
                endcase
            end
        end
        // External interrupt pin: no pull and no request while disabled
        next_irq_pull_up   = irq_ctrl[IRQ_EN_BIT] && irq_ctrl[IRQ_PE_BIT]
                             && !irq_ctrl[IRQ_RISE_BIT];  // RULE2 RULE3
        next_irq_pull_down = irq_ctrl[IRQ_EN_BIT] && irq_ctrl[IRQ_PE_BIT]
                             && irq_ctrl[IRQ_RISE_BIT];   // RULE2 RULE3
        next_irq_request   = irq_ctrl[IRQ_EN_BIT]
                             && (irq_ctrl[IRQ_RISE_BIT] ? irq_sync
                                                        : !irq_sync); // RULE1
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_dout        <= PIN_RESET; // RULE4
            port_dir         <= PIN_RESET; // RULE4
            port_pull        <= PIN_RESET; // RULE4
            irq_ctrl         <= IRQ_RESET; // RULE2
            irq_pull_up      <= 1'b0;
            irq_pull_down    <= 1'b0;
            irq_request      <= 1'b0;
            branch_pin_level <= 1'b0;
        end else begin
            port_dout        <= next_port_dout;
            port_dir         <= next_port_dir;
            port_pull        <= next_port_pull;
            irq_ctrl         <= next_irq_ctrl;
            irq_pull_up      <= next_irq_pull_up;
            irq_pull_down    <= next_irq_pull_down;
            irq_request      <= next_irq_request;
            branch_pin_level <= irq_sync; // RULE1
        end
    end

    // ==========================================================
    // Per-pin ownership
    // ==========================================================
    // No register here: a peripheral taking a pin must see it at once
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        spom_pin_select #(
            .HAS_LO (LO_MASK[i]),
            .HAS_HI (HI_MASK[i]),
            .IS_KBI (KBI_MASK[i])
        ) u_pin (
            .hi_en     (alt_hi.en[i]),
            .hi_out    (alt_hi.out[i]),
            .hi_oe     (alt_hi.oe[i]),
            .lo_en     (alt_lo.en[i]),
            .lo_out    (alt_lo.out[i]),
            .lo_oe     (alt_lo.oe[i]),
            .kbi_rise  (kbi_rise_sense[i]),
            .port_dout (port_dout[i]),
            .port_dir  (port_dir[i]),
            .pull_en   (port_pull[i]),
            .pad_out   (pad.out[i]),
            .pad_oe    (pad.oe[i]),
            .pull_up   (pad.pull_up[i]),
            .pull_down (pad.pull_down[i]),
            .owner     (owner[i])
        ); // RULE13
    end

endmodule // spom_top
